// ---- verilog/timer_units_defines.vh ----
// Register map, field positions, reset values and prescaler bases of the timer units
`ifndef TIMER_UNITS_DEFINES_VH
`define TIMER_UNITS_DEFINES_VH
// Register groups: address[7:5]; entry within group: address[4:2]
`define GRP_VAL    3'h0
`define GRP_CTL    3'h1
`define GRP_IRQ    3'h2
`define SUB_CR     3'h5
`define NUM_TMR    3'h5
`define NUM_IRQ    3'h6
// Control word fields
`define F_PRE      2:0
`define F_MODE     4:3
`define F_RUN      5
`define F_DOWN     6
`define F_EXTDIR   7
`define F_GPOL     8
`define F_ERISE    9
`define F_EFALL    10
`define F_CONCAT   11
`define F_AFUNC    13:12
`define F_CEDGE    13:12
`define F_CCLR     14
`define F_OUTEN    14
`define F_TRIG     15:14
// Interrupt control word fields
`define F_PRIO     3:0
`define F_IEN      6
`define F_IFLAG    7
// Modes
`define M_TIMER    2'h0
`define M_GATED    2'h1
`define M_COUNT    2'h2
`define M_INC      2'h3
// Auxiliary functions
`define AF_CAP     2'h1
`define AF_RLD     2'h2
// Reload triggers
`define TR_PIN     2'h0
`define TR_RISE    2'h1
`define TR_FALL    2'h2
// Smallest prescaler factors of each group
`define G1_DIV0    11'h008
`define G2_DIV0    11'h004
// Reset values
`define CTL_RST    16'h0000
`define VAL_RST    16'h0000
`endif

// ---- verilog/general_purpose_timer_units.v ----
// Five 16-bit timers in two groups with capture/reload, behind an Avalon-MM slave
`timescale 1ns/10ps
`include "timer_units_defines.vh"

module general_purpose_timer_units (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Timer pins: 0 aux A, 1 core, 2 aux B, 3 capture, 4 base
  input  wire [4:0]  timerIn,
  input  wire [4:0]  dirIn,
  input  wire        captureIn,
  // Toggle outputs and interrupt requests
  output reg         coreOut,
  output reg         baseOut,
  output reg  [5:0]  irqReq
);

  // Prescale counter width: wide enough for the largest factor, 1024
  localparam PW = 11;

  //////////////////////////////////////////////////////////////////////////////
  // State
  // Timer values and control words are packed 16 bits per timer, timer 0 lowest
  reg  [4:0]    in1_q, in2_q, in3_q;
  reg  [4:0]    dir1_q, dir2_q, dir3_q;
  reg           cap1_q, cap2_q, cap3_q;
  reg  [PW-1:0] presc_q;
  reg  [79:0]   tval_q;
  reg  [79:0]   ctl_q;
  reg  [15:0]   cr_q;
  reg           coreLatch_q, baseLatch_q;
  reg  [5:0]    flag_q, en_q;
  reg  [23:0]   prio_q;
  reg           ack_q;
  reg  [31:0]   rdMux;
  // Next values and per-timer wrap, capture and reload events
  wire [79:0]   tval_d;
  wire [4:0]    wrapV, capV, rldV;
  wire [5:0]    flag_d;
  // Bus decode: register group and entry within it
  wire [2:0]    grp = address[7:5];
  wire [2:0]    sub = address[4:2];
  wire          req = read | write;
  wire          wrEn = write & ack_q;
  // Capture timer control also selects the capture register edge
  wire [15:0]   capCtl = ctl_q[63:48];
  wire          coreWrap = wrapV[1];
  wire          baseWrap = wrapV[4];
  wire          crCap;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, write and read data at the released edge
  assign waitrequest = req & ~ack_q;

  always @(posedge clk) begin
    if (rst) begin
      ack_q    <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (read & ~ack_q) begin
        readdata <= rdMux;
      end
    end
  end

  // Read decode; unmapped addresses read zero
  // Interrupt word: flag, enable, two spare zero bits, priority
  always @* begin
    rdMux = 32'h00000000;
    case (grp)
      `GRP_VAL: begin
        if (sub < `NUM_TMR) begin
          rdMux = {16'h0000, tval_q[16*sub +: 16]};
        end else if (sub == `SUB_CR) begin
          rdMux = {16'h0000, cr_q};
        end
      end
      `GRP_CTL: begin
        if (sub < `NUM_TMR) begin
          rdMux = {16'h0000, ctl_q[16*sub +: 16]};
        end
      end
      `GRP_IRQ: begin
        if (sub < `NUM_IRQ) begin
          rdMux = {24'h000000, flag_q[sub], en_q[sub], 2'h0, prio_q[4*sub +: 4]};
        end
      end
      default: rdMux = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges come from the second and third stages
  // Only the second and third stages feed logic; the first may still be settling
  always @(posedge clk) begin
    if (rst) begin
      in1_q  <= 5'h00;
      in2_q  <= 5'h00;
      in3_q  <= 5'h00;
      dir1_q <= 5'h00;
      dir2_q <= 5'h00;
      dir3_q <= 5'h00;
      cap1_q <= 1'b0;
      cap2_q <= 1'b0;
      cap3_q <= 1'b0;
    end else begin
      in1_q  <= timerIn;
      in2_q  <= in1_q;
      in3_q  <= in2_q;
      dir1_q <= dirIn;
      dir2_q <= dir1_q;
      dir3_q <= dir2_q;
      cap1_q <= captureIn;
      cap2_q <= cap1_q;
      cap3_q <= cap2_q;
    end
  end

  // Capture pin edge for the capture/reload register; rise, fall or both
  wire [1:0]    capEdge = capCtl[`F_CEDGE];
  assign crCap = (capEdge[0] & cap2_q & ~cap3_q) | (capEdge[1] & ~cap2_q & cap3_q);

  //////////////////////////////////////////////////////////////////////////////
  // Per-timer count, direction and load logic
  genvar i;
  generate
    for (i = 0; i < 5; i = i + 1) begin : tmr
      // Control word, value and role of this timer
      wire [15:0]   c     = ctl_q[16*i +: 16];
      wire [15:0]   v     = tval_q[16*i +: 16];
      wire          g2    = (i >= 3);
      wire          isAux = (i == 0) || (i == 2);
      // Prescale tick once per factor of CPU clocks
      wire [PW-1:0] d0    = g2 ? `G2_DIV0 : `G1_DIV0;
      wire [PW-1:0] m     = (d0 << c[`F_PRE]) - 11'h001;
      wire          pre   = (presc_q & m) == m;
      // Gate level and pin edges from the synchronised samples
      wire          lvl   = in2_q[i] ^ c[`F_GPOL];
      wire          pinEd = (c[`F_ERISE] & in2_q[i] & ~in3_q[i]) |
                            (c[`F_EFALL] & ~in2_q[i] & in3_q[i]);
      wire          abEd  = (in2_q[i] ^ in3_q[i]) | (dir2_q[i] ^ dir3_q[i]);
      wire          latEd = isAux ? coreWrap : ((i == 3) ? baseWrap : 1'b0);
      // Only the auxiliaries and the capture timer may be clocked by a latch
      wire          cat   = c[`F_CONCAT] & (isAux | (i == 3));
      // Incremental decoding exists only in the first group
      wire          inc   = (c[`F_MODE] == `M_INC) & ~g2;
      wire          hold  = isAux & (c[`F_AFUNC] != 2'h0);
      // Per-timer results
      reg           tick;
      reg           trig;
      wire          step;
      wire          dn;
      wire [15:0]   cnt;
      wire          ld;
      wire [15:0]   ldv;
      wire          wrVal = wrEn & (grp == `GRP_VAL) & (sub == i);

      // Count source per mode
      always @* begin
        case (c[`F_MODE])
          `M_TIMER: tick = pre;
          `M_GATED: tick = pre & lvl;
          `M_COUNT: tick = cat ? latEd : pinEd;
          `M_INC:   tick = g2 ? pinEd : abEd;
          default:  tick = 1'b0;
        endcase
      end

      // Reload trigger of an auxiliary timer
      always @* begin
        case (c[`F_TRIG])
          `TR_PIN:  trig = pinEd;
          `TR_RISE: trig = coreWrap & ~coreLatch_q;
          `TR_FALL: trig = coreWrap & coreLatch_q;
          default:  trig = coreWrap;
        endcase
      end

      // Capture or reload duty freezes an auxiliary timer
      assign step = c[`F_RUN] & tick & ~hold;
      // Incremental: direction from previous A against present B
      assign dn = inc ? (in3_q[i] ^ dir2_q[i] ^ c[`F_DOWN]) :
                        (c[`F_DOWN] ^ (c[`F_EXTDIR] & dir2_q[i]));
      // Next count; a wrap past either end is the overflow event
      assign cnt = dn ? v - 16'h0001 : v + 16'h0001;
      assign wrapV[i] = step & (dn ? (v == 16'h0000) : (&v));
      // Capture and reload requests of the auxiliary timers
      assign capV[i] = isAux & (c[`F_AFUNC] == `AF_CAP) & pinEd;
      assign rldV[i] = isAux & (c[`F_AFUNC] == `AF_RLD) & trig;

      // Hardware loads per timer
      if (i == 1) begin : core
        assign ld  = rldV[0] | rldV[2];
        assign ldv = rldV[0] ? tval_q[15:0] : tval_q[47:32];
      end else if (i == 3) begin : capt
        assign ld  = crCap & capCtl[`F_CCLR];
        assign ldv = 16'h0000;
      end else if (i == 4) begin : base
        assign ld  = wrapV[4];
        assign ldv = cr_q;
      end else begin : aux
        assign ld  = capV[i];
        assign ldv = tval_q[31:16];
      end

      // A bus write wins over a hardware load, a load over counting
      assign tval_d[16*i +: 16] = wrVal ? writedata[15:0] : (ld ? ldv : (step ? cnt : v));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: hardware set wins over a software clear
  assign flag_d[4:0] = wrapV | capV;
  assign flag_d[5]   = crCap;

  always @(posedge clk) begin : irqRegs
    integer k;
    if (rst) begin
      flag_q <= 6'h00;
      en_q   <= 6'h00;
      prio_q <= 24'h000000;
      irqReq <= 6'h00;
    end else begin
      for (k = 0; k < 6; k = k + 1) begin
        if (wrEn && grp == `GRP_IRQ && sub == k[2:0]) begin
          flag_q[k]         <= flag_d[k] | writedata[`F_IFLAG];
          en_q[k]           <= writedata[`F_IEN];
          prio_q[4*k +: 4]  <= writedata[`F_PRIO];
        end else begin
          flag_q[k] <= flag_d[k] | flag_q[k];
        end
      end
      // Request level follows flag and enable one edge later
      irqReq <= flag_q & en_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timers, controls, capture register, prescaler and toggle latches
  always @(posedge clk) begin : core
    integer k;
    if (rst) begin
      presc_q     <= 11'h000;
      tval_q      <= {5{`VAL_RST}};
      ctl_q       <= {5{`CTL_RST}};
      cr_q        <= `VAL_RST;
      coreLatch_q <= 1'b0;
      baseLatch_q <= 1'b0;
      coreOut     <= 1'b0;
      baseOut     <= 1'b0;
    end else begin
      // Free-running prescale counter shared by all timers
      presc_q <= presc_q + 11'h001;
      tval_q  <= tval_d;
      // Control words written from the bus
      for (k = 0; k < 5; k = k + 1) begin
        if (wrEn && grp == `GRP_CTL && sub == k[2:0]) begin
          ctl_q[16*k +: 16] <= writedata[15:0];
        end
      end
      // A bus write to the capture register wins over a capture
      if (wrEn && grp == `GRP_VAL && sub == `SUB_CR) begin
        cr_q <= writedata[15:0];
      end else if (crCap) begin
        cr_q <= tval_q[63:48];
      end
      // Latches flip on every wrap; pins follow when enabled
      coreLatch_q <= coreLatch_q ^ coreWrap;
      baseLatch_q <= baseLatch_q ^ baseWrap;
      coreOut     <= (coreLatch_q ^ coreWrap) & ctl_q[16 + `F_OUTEN];
      baseOut     <= (baseLatch_q ^ baseWrap) & ctl_q[64 + `F_OUTEN];
    end
  end

endmodule

// ---- sim/timer_units_asserts.sv ----
// Bus timing and reset checks on the timer unit ports
`timescale 1ns/10ps
module timer_units_asserts (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Bus
  input wire        read,
  input wire        write,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Outputs
  input wire        coreOut,
  input wire        baseOut,
  input wire [5:0]  irqReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Any pending request
  wire req = read | write;
  AST_IDLE: assert property (!req |-> !waitrequest)
    else $error("wait raised while idle");
  AST_FIRST: assert property ($rose(req) |-> waitrequest)
    else $error("request taken without wait cycle");
  AST_ONE: assert property (req && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  AST_B2B: assert property (req && !waitrequest ##1 req |-> waitrequest)
    else $error("back to back request not waited");
  AST_HOLD: assert property ($changed(readdata) |-> $past(read && waitrequest))
    else $error("read data moved without a read");
  AST_WRD: assert property (write |=> $stable(readdata))
    else $error("write disturbed read data");
  AST_HI: assert property (readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_RST: assert property ($fell(rst) |-> !coreOut && !baseOut && irqReq == 6'h00)
    else $error("outputs active after reset");
endmodule

bind general_purpose_timer_units timer_units_asserts i_chk (.clk(clk), .rst(rst), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest), .coreOut(coreOut),
  .baseOut(baseOut), .irqReq(irqReq));

// ---- sim/ext_pins.sv ----
// Model of the external count, gate, direction and capture pins
`timescale 1ns/10ps
module ext_pins (
  // Clock
  input wire       clk,
  // Pins
  output reg [4:0] timerIn,
  output reg [4:0] dirIn,
  output reg       captureIn
);
  // Quiet pins: count, direction and capture inputs all start low
  initial begin
    timerIn = 5'h00;
    dirIn = 5'h00;
    captureIn = 1'b0;
  end
  // New levels held four cycles so the synchroniser sees each one
  task automatic step(input [4:0] t, input [4:0] d, input c);
    @(posedge clk);
    timerIn <= t;
    dirIn <= d;
    captureIn <= c;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the timer units
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_top;
  // Bench signals
  logic        clk, rst, read, write, waitrequest, coreOut, baseOut, captureIn;
  logic [7:0]  address;
  logic [31:0] writedata, readdata;
  logic [5:0]  irqReq;
  logic [4:0]  timerIn, dirIn;
  logic [15:0] rv, r0;
  int          errors, num_checks, sp;
  // Address, write value, read back value
  logic [39:0] rows [8] = '{40'h00_1234_1234, 40'h04_ABCD_ABCD, 40'h08_5A5A_5A5A,
    40'h0C_00FF_00FF, 40'h10_FFFF_FFFF, 40'h20_0007_0007, 40'h40_004F_004F, 40'h18_1111_0000};
  general_purpose_timer_units i_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .timerIn(timerIn), .dirIn(dirIn), .captureIn(captureIn), .coreOut(coreOut),
    .baseOut(baseOut), .irqReq(irqReq));
  ext_pins i_pins (.clk(clk), .timerIn(timerIn), .dirIn(dirIn), .captureIn(captureIn));
  // Clock and idle bus
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    forever #50 clk = ~clk;
  end
  // One transfer, held until waitrequest is low at a rising edge
  task automatic xfer(input w, input [7:0] a, input [15:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {16'h0000, d};
    do @(posedge clk); while (waitrequest);
    rv = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial begin
    #(30000 * 100);
    errors++;
    end_sim();
  end
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    xfer(0, 8'h04, 16'h0000);
    `CHK("core reset", 16'h0000, rv)
    foreach (rows[i]) begin
      xfer(1, rows[i][39:32], rows[i][31:16]);
      xfer(0, rows[i][39:32], 16'h0000);
      `CHK("row", rows[i][15:0], rv)
    end
    // Core wraps up, sets its flag and toggles its pin
    xfer(1, 8'h04, 16'hFFFF);
    xfer(1, 8'h44, 16'h0040);
    xfer(1, 8'h24, 16'h4020);
    for (int n = 0; n < 40 && irqReq[1] !== 1'b1; n++) @(posedge clk);
    @(posedge clk);
    `CHK("core flag", 1'b1, irqReq[1])
    `CHK("core pin", 1'b1, coreOut)
    // Two counts per measured span at every prescaler code of both groups
    xfer(1, 8'h10, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 8; c++) begin
        sp = (t == 0 ? 16 : 8) << c;
        xfer(1, t == 0 ? 8'h24 : 8'h30, 16'h4020 | c);
        xfer(0, t == 0 ? 8'h04 : 8'h10, 16'h0000);
        r0 = rv;
        repeat (sp - 3) @(posedge clk);
        xfer(0, t == 0 ? 8'h04 : 8'h10, 16'h0000);
        `CHK("rate", 16'h0002, 16'(rv - r0))
      end
    end
    // Counter mode on rising pin edges, then direction pin turns it down
    xfer(1, 8'h00, 16'h0000);
    xfer(1, 8'h20, 16'h0230);
    for (int n = 0; n < 3; n++) begin
      i_pins.step(5'h01, 5'h00, 1'b0);
      i_pins.step(5'h00, 5'h00, 1'b0);
    end
    xfer(0, 8'h00, 16'h0000);
    `CHK("count up", 16'h0003, rv)
    xfer(1, 8'h20, 16'h02B0);
    i_pins.step(5'h00, 5'h01, 1'b0);
    for (int n = 0; n < 2; n++) begin
      i_pins.step(5'h01, 5'h01, 1'b0);
      i_pins.step(5'h00, 5'h01, 1'b0);
    end
    xfer(0, 8'h00, 16'h0000);
    `CHK("count down", 16'h0001, rv)
    // Quadrature: one forward cycle gives four counts
    i_pins.step(5'h00, 5'h00, 1'b0);
    xfer(1, 8'h00, 16'h0000);
    xfer(1, 8'h20, 16'h0038);
    i_pins.step(5'h01, 5'h00, 1'b0);
    i_pins.step(5'h01, 5'h01, 1'b0);
    i_pins.step(5'h00, 5'h01, 1'b0);
    i_pins.step(5'h00, 5'h00, 1'b0);
    xfer(0, 8'h00, 16'h0000);
    `CHK("quadrature", 16'h0004, rv)
    // Gated timer holds while gate is low, runs while high
    xfer(1, 8'h08, 16'h0000);
    xfer(1, 8'h28, 16'h0028);
    repeat (40) @(posedge clk);
    xfer(0, 8'h08, 16'h0000);
    `CHK("gate closed", 16'h0000, rv)
    i_pins.step(5'h04, 5'h00, 1'b0);
    repeat (40) @(posedge clk);
    xfer(0, 8'h08, 16'h0000);
    `CHK("gate open", 1'b1, rv != 16'h0000)
    // Stopped auxiliary captures the core value on a pin edge
    xfer(1, 8'h24, 16'h0000);
    xfer(1, 8'h04, 16'hBEEF);
    xfer(1, 8'h28, 16'h1220);
    i_pins.step(5'h00, 5'h00, 1'b0);
    i_pins.step(5'h04, 5'h00, 1'b0);
    xfer(0, 8'h08, 16'h0000);
    `CHK("aux capture", 16'hBEEF, rv)
    // Capture register latches capture timer, clears it, flags it
    xfer(1, 8'h0C, 16'h0100);
    xfer(1, 8'h2C, 16'h5000);
    xfer(1, 8'h54, 16'h0040);
    i_pins.step(5'h00, 5'h00, 1'b1);
    xfer(0, 8'h14, 16'h0000);
    `CHK("capture reg", 16'h0100, rv)
    xfer(0, 8'h0C, 16'h0000);
    `CHK("capture clear", 16'h0000, rv)
    `CHK("capture flag", 1'b1, irqReq[5])
    xfer(1, 8'h54, 16'h0040);
    repeat (2) @(posedge clk);
    `CHK("flag cleared", 1'b0, irqReq[5])
    // Base wraps on one pin edge: reloads from the capture register, toggles its pin
    xfer(1, 8'h10, 16'hFFFF);
    xfer(1, 8'h50, 16'h0040);
    xfer(1, 8'h30, 16'h4230);
    i_pins.step(5'h10, 5'h00, 1'b0);
    xfer(0, 8'h10, 16'h0000);
    `CHK("base reload", 16'h0100, rv)
    `CHK("base pin", 1'b1, baseOut)
    `CHK("base flag", 1'b1, irqReq[4])
    // Mid-run reset clears pins, flags and timers
    i_pins.step(5'h00, 5'h00, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("reset outs", 3'h0, {coreOut, baseOut, irqReq != 6'h00})
    xfer(0, 8'h10, 16'h0000);
    `CHK("reset base", 16'h0000, rv)
    // Core reloaded alternately from each auxiliary on opposite latch edges
    xfer(1, 8'h04, 16'hFFFF);
    xfer(1, 8'h00, 16'h1111);
    xfer(1, 8'h08, 16'h2222);
    xfer(1, 8'h20, 16'h6020);
    xfer(1, 8'h28, 16'hA020);
    xfer(1, 8'h24, 16'h0230);
    i_pins.step(5'h02, 5'h00, 1'b0);
    i_pins.step(5'h00, 5'h00, 1'b0);
    xfer(0, 8'h04, 16'h0000);
    `CHK("reload rise", 16'h1111, rv)
    xfer(1, 8'h04, 16'hFFFF);
    i_pins.step(5'h02, 5'h00, 1'b0);
    i_pins.step(5'h00, 5'h00, 1'b0);
    xfer(0, 8'h04, 16'h0000);
    `CHK("reload fall", 16'h2222, rv)
    xfer(0, 8'h00, 16'h0000);
    `CHK("reload aux held", 16'h1111, rv)
    // Auxiliary counts core wraps when concatenated
    xfer(1, 8'h20, 16'h0830);
    xfer(1, 8'h00, 16'h0000);
    xfer(1, 8'h04, 16'hFFFF);
    i_pins.step(5'h02, 5'h00, 1'b0);
    xfer(0, 8'h00, 16'h0000);
    `CHK("concat", 16'h0001, rv)
    end_sim();
  end
endmodule
